/* hdl/logic_compare_call_exec.sv */
// Execution unit for conjunction, call, clock-mode write and compares, APB attached
`timescale 1ns/100ps
`default_nettype none

module logic_compare_call_exec
  import logic_compare_call_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hubGrant,
  output logic             hubReq,
  output logic      [7:0]  clockMode
);

  typedef struct packed {
    phase_t             phase;
    logic [4:0]         cnt;
    instr_t             ins;
    logic               doIt;
    logic [31:0]        dVal;
    logic [31:0]        sVal;
    logic [8:0]         pc;
    logic               zf;
    logic               cf;
    logic [7:0]         clkMode;
    logic               hubReq;
    logic [8:0]         regIdx;
    logic               accept;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic [511:0][31:0] regs;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  // Only the clock-mode write among hub operations is handled here
  function automatic logic isSupported(input instr_t w);
    logic ok;
    ok = 1'b0;
    unique case (w.op)
      OP_AND, OP_BIT_CLEAR, OP_JUMP_LINK, OP_UCOMPARE, OP_SCOMPARE: ok = 1'b1;
      OP_HUB: ok = (w.src[2:0] == HUB_CLOCK_MODE_WRITE);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic condMet(input logic [3:0] c, input logic z, input logic cy);
    return c[{cy, z}];
  endfunction

  logic        busy;
  logic        execDone;
  logic        hubDone;
  logic [31:0] logicRes;
  logic [31:0] diffRes;
  logic        uBorrow;
  logic        sBorrow;
  logic        apbAccess;
  instr_t      newIns;

  assign busy      = (st_r.phase != PH_IDLE);
  assign execDone  = (st_r.phase == PH_EXEC) && (st_r.cnt == EXEC_LAST);
  // Earliest window is taken only after the minimum count, so a grant seen early
  // costs one rotation; the hub rotation bounds the total at the upper figure.
  assign hubDone   = (st_r.phase == PH_HUB) && (st_r.cnt >= HUB_LAST) && hubGrant;
  assign logicRes  = (st_r.ins.op == OP_BIT_CLEAR) ? (st_r.dVal & ~st_r.sVal)
                                                   : (st_r.dVal & st_r.sVal);
  assign diffRes   = st_r.dVal - st_r.sVal;
  assign uBorrow   = st_r.dVal < st_r.sVal;
  // Strict less-than: borrow of the signed subtraction, not less-or-equal
  assign sBorrow   = $signed(st_r.dVal) < $signed(st_r.sVal);
  assign apbAccess = psel && penable;
  assign newIns    = instr_t'(pwdata);

  always_comb begin
    st_nxt = st_r;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;

    // Execution engine
    unique case (st_r.phase)
      PH_IDLE: begin
        st_nxt.cnt = 5'h00;
      end
      PH_EXEC: begin
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (execDone) begin
          st_nxt.phase = PH_IDLE;
          st_nxt.cnt   = 5'h00;
          st_nxt.pc    = st_r.pc + 9'h001;
          if (st_r.doIt) begin
            unique case (st_r.ins.op)
              OP_AND, OP_BIT_CLEAR: begin
                if (st_r.ins.zeroWr) begin
                  st_nxt.zf = (logicRes == 32'h0000_0000);
                end
                if (st_r.ins.carryWr) begin
                  st_nxt.cf = ^logicRes;
                end
                if (st_r.ins.resultWr) begin
                  st_nxt.regs[st_r.ins.dest] = logicRes;
                end
              end
              OP_JUMP_LINK: begin
                // The link lands in the return slot itself, no stack is kept
                if (st_r.ins.resultWr) begin
                  st_nxt.regs[st_r.ins.dest][8:0] = st_r.pc + 9'h001;
                end
                st_nxt.pc = st_r.sVal[8:0];
              end
              OP_UCOMPARE, OP_SCOMPARE: begin
                if (st_r.ins.zeroWr) begin
                  st_nxt.zf = (st_r.dVal == st_r.sVal);
                end
                if (st_r.ins.carryWr) begin
                  st_nxt.cf = (st_r.ins.op == OP_SCOMPARE) ? sBorrow : uBorrow;
                end
                if (st_r.ins.resultWr) begin
                  st_nxt.regs[st_r.ins.dest] = diffRes;
                end
              end
              default: begin
                st_nxt.pc = st_r.pc + 9'h001;
              end
            endcase
          end
        end
      end
      PH_HUB: begin
        if (st_r.cnt != 5'h1f) begin
          st_nxt.cnt = st_r.cnt + 5'h01;
        end
        if (hubDone) begin
          st_nxt.phase   = PH_IDLE;
          st_nxt.cnt     = 5'h00;
          st_nxt.hubReq  = 1'b0;
          st_nxt.clkMode = st_r.dVal[7:0];
          st_nxt.pc      = st_r.pc + 9'h001;
        end
      end
      default: begin
        st_nxt.phase  = PH_IDLE;
        st_nxt.cnt    = 5'h00;
        st_nxt.hubReq = 1'b0;
      end
    endcase

    // APB first access edge: decide answer and error, raise pready
    if (apbAccess && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.accept = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
      if (pwrite) begin
        unique case (paddr)
          OFS_INSTR: begin
            st_nxt.accept = !busy && isSupported(newIns);
          end
          OFS_PC, OFS_REG_DATA: begin
            // Refused while busy so software cannot race the writeback
            st_nxt.accept = !busy;
          end
          OFS_REG_INDEX, OFS_STATUS: begin
            st_nxt.accept = 1'b1;
          end
          default: begin
            st_nxt.accept = 1'b0;
          end
        endcase
      end else begin
        unique case (paddr)
          OFS_INSTR:     st_nxt.prdata = st_r.ins;
          OFS_PC:        st_nxt.prdata = {23'h000000, st_r.pc};
          OFS_STATUS: begin
            st_nxt.prdata[STAT_BUSY_BIT]  = busy;
            st_nxt.prdata[STAT_ZERO_BIT]  = st_r.zf;
            st_nxt.prdata[STAT_CARRY_BIT] = st_r.cf;
            st_nxt.prdata[STAT_MODE_LSB +: 8] = st_r.clkMode;
          end
          OFS_REG_INDEX: st_nxt.prdata = {23'h000000, st_r.regIdx};
          OFS_REG_DATA:  st_nxt.prdata = st_r.regs[st_r.regIdx];
          default:       st_nxt.accept = 1'b0;
        endcase
      end
      st_nxt.pslverr = !st_nxt.accept;
    end

    // APB completing edge: the write takes effect here and only here
    if (apbAccess && st_r.pready && pwrite && st_r.accept) begin
      unique case (paddr)
        OFS_INSTR: begin
          st_nxt.ins  = newIns;
          st_nxt.doIt = condMet(newIns.cond, st_r.zf, st_r.cf);
          st_nxt.dVal = st_r.regs[newIns.dest];
          st_nxt.sVal = newIns.imm ? {23'h000000, newIns.src}
                                   : st_r.regs[newIns.src];
          st_nxt.cnt  = 5'h00;
          if ((newIns.op == OP_HUB) && st_nxt.doIt) begin
            st_nxt.phase  = PH_HUB;
            st_nxt.hubReq = 1'b1;
          end else begin
            st_nxt.phase = PH_EXEC;
          end
        end
        OFS_PC:        st_nxt.pc = pwdata[8:0];
        OFS_REG_INDEX: st_nxt.regIdx = pwdata[8:0];
        OFS_REG_DATA:  st_nxt.regs[st_r.regIdx] = pwdata;
        default:       st_nxt.accept = st_r.accept;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r         <= '0;
      st_r.phase   <= PH_IDLE;
      st_r.pc      <= PC_RST;
      st_r.clkMode <= CLOCK_MODE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata    = st_r.prdata;
  assign pready    = st_r.pready;
  assign pslverr   = st_r.pslverr;
  assign hubReq    = st_r.hubReq;
  assign clockMode = st_r.clkMode;

  // Reference values for the checks below
  logic [31:0] andRef;
  logic [31:0] bicRef;
  logic        retLogic;
  assign andRef   = st_r.dVal & st_r.sVal;
  assign bicRef   = st_r.dVal & ~st_r.sVal;
  assign retLogic = execDone && st_r.doIt &&
                    ((st_r.ins.op == OP_AND) || (st_r.ins.op == OP_BIT_CLEAR));

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence sExecStart;
    $rose(busy) && (st_r.phase == PH_EXEC);
  endsequence

  sequence sHubStart;
    $rose(busy) && (st_r.phase == PH_HUB);
  endsequence

  AST_AND_RESULT: assert property (
    execDone && st_r.doIt && (st_r.ins.op == OP_AND) && st_r.ins.resultWr
    |=> st_r.regs[$past(st_r.ins.dest)] == $past(andRef))
    else $error("conjunction result not written");

  AST_BIC_RESULT: assert property (
    execDone && st_r.doIt && (st_r.ins.op == OP_BIT_CLEAR) && st_r.ins.resultWr
    |=> st_r.regs[$past(st_r.ins.dest)] == $past(bicRef))
    else $error("bit clear result not written");

  AST_IMM_SOURCE: assert property (
    $rose(busy) && st_r.ins.imm |-> st_r.sVal == {23'h000000, st_r.ins.src})
    else $error("immediate source not zero extended");

  AST_ZERO_FLAG: assert property (
    retLogic && st_r.ins.zeroWr && (st_r.ins.op == OP_AND)
    |=> st_r.zf == ($past(andRef) == 32'h0000_0000))
    else $error("zero flag wrong after conjunction");

  AST_PARITY: assert property (
    retLogic && st_r.ins.carryWr && (st_r.ins.op == OP_BIT_CLEAR)
    |=> st_r.cf == ^$past(bicRef))
    else $error("carry flag is not parity of result");

  AST_NO_RESULT: assert property (
    execDone && !st_r.ins.resultWr
    |=> st_r.regs[$past(st_r.ins.dest)] == $past(st_r.regs[st_r.ins.dest]))
    else $error("destination changed under no-result effect");

  AST_CALL_LINK: assert property (
    execDone && st_r.doIt && (st_r.ins.op == OP_JUMP_LINK) && st_r.ins.resultWr
    |=> (st_r.regs[$past(st_r.ins.dest)][8:0] == $past(st_r.pc) + 9'h001) &&
        (st_r.pc == $past(st_r.sVal[8:0])))
    else $error("call link or jump wrong");

  AST_CLOCK_MODE: assert property (
    hubDone |=> (clockMode == $past(st_r.dVal[7:0])) && ($stable(st_r.zf)) && !hubReq)
    else $error("clock mode not loaded from destination");

  AST_HUB_MIN: assert property (
    sHubStart |-> busy [*7])
    else $error("hub operation finished too early");

  AST_UCOMPARE: assert property (
    execDone && st_r.doIt && (st_r.ins.op == OP_UCOMPARE) && st_r.ins.carryWr
    |=> st_r.cf == ($past(st_r.dVal) < $past(st_r.sVal)))
    else $error("unsigned borrow wrong");

  AST_SCOMPARE: assert property (
    execDone && st_r.doIt && (st_r.ins.op == OP_SCOMPARE) && st_r.ins.carryWr
    |=> st_r.cf == ($signed($past(st_r.dVal)) < $signed($past(st_r.sVal))))
    else $error("signed borrow wrong");

  AST_COMPARE_ZERO: assert property (
    execDone && st_r.doIt && st_r.ins.zeroWr &&
    ((st_r.ins.op == OP_UCOMPARE) || (st_r.ins.op == OP_SCOMPARE))
    |=> st_r.zf == ($past(st_r.dVal) == $past(st_r.sVal)))
    else $error("compare zero flag wrong");

  AST_CALL_NO_LINK: assert property (
    execDone && st_r.doIt && (st_r.ins.op == OP_JUMP_LINK) && !st_r.ins.resultWr
    |=> (st_r.pc == $past(st_r.sVal[8:0])) &&
        (st_r.regs[$past(st_r.ins.dest)] == $past(st_r.regs[st_r.ins.dest])))
    else $error("call without link changed state wrongly");

  AST_FOUR_CYCLES: assert property (
    sExecStart |-> busy [*4] ##1 !busy)
    else $error("instruction did not take four cycles");

endmodule

`default_nettype wire

/* pkg/logic_compare_call_pkg.sv */
// Shared constants and types of the logic, compare and call execution block
package logic_compare_call_pkg;

  // Instruction word layout, high bit first
  typedef struct packed {
    logic [5:0] op;
    logic       zeroWr;
    logic       carryWr;
    logic       resultWr;
    logic       imm;
    logic [3:0] cond;
    logic [8:0] dest;
    logic [8:0] src;
  } instr_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_EXEC = 2'b01,
    PH_HUB  = 2'b10
  } phase_t;

  // Opcodes
  localparam logic [5:0] OP_AND        = 6'h18;
  localparam logic [5:0] OP_BIT_CLEAR  = 6'h19;
  localparam logic [5:0] OP_JUMP_LINK  = 6'h17;
  localparam logic [5:0] OP_HUB        = 6'h03;
  localparam logic [5:0] OP_UCOMPARE   = 6'h21;
  localparam logic [5:0] OP_SCOMPARE   = 6'h30;
  localparam logic [2:0] HUB_CLOCK_MODE_WRITE = 3'h0;
  localparam logic [3:0] COND_ALWAYS   = 4'hf;

  // Register byte offsets
  localparam logic [7:0] OFS_INSTR     = 8'h00;
  localparam logic [7:0] OFS_PC        = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_REG_INDEX = 8'h0c;
  localparam logic [7:0] OFS_REG_DATA  = 8'h10;

  // Status field positions
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_ZERO_BIT   = 1;
  localparam int STAT_CARRY_BIT  = 2;
  localparam int STAT_MODE_LSB   = 8;

  // Reset values
  localparam logic [8:0] PC_RST         = 9'h000;
  localparam logic [7:0] CLOCK_MODE_RST = 8'h00;

  // Cycle counts
  localparam int EXEC_CYCLES    = 4;
  localparam int HUB_MIN_CYCLES = 7;
  localparam int HUB_MAX_CYCLES = 22;
  localparam logic [4:0] EXEC_LAST = 5'(EXEC_CYCLES - 1);
  localparam logic [4:0] HUB_LAST  = 5'(HUB_MIN_CYCLES - 1);

endpackage

/* dv/hub_window_model.sv */
// Hub arbiter model: one rotating access window per slot round
`timescale 1ns/100ps
`default_nettype none
module hub_window_model #(
  parameter int SLOTS   = 16,
  parameter int MY_SLOT = 5
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        storeLong0,
  input  wire logic [31:0] long0Data,
  output logic             hubGrant,
  output logic      [31:0] long0
);
  logic [4:0]  slot_r;
  logic [4:0]  slot_nxt;
  // Main memory long 0, where the program keeps the system clock frequency
  logic [31:0] long0_r;

  // Window turns whether or not the core asks, so the wait depends on issue time
  always_comb begin
    slot_nxt = (slot_r == 5'(SLOTS - 1)) ? 5'h00 : slot_r + 5'h01;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      slot_r  <= 5'h00;
      long0_r <= 32'h0000_0000;
    end else begin
      slot_r <= slot_nxt;
      if (storeLong0) begin
        long0_r <= long0Data;
      end
    end
  end

  assign hubGrant = (slot_r == 5'(MY_SLOT));
  assign long0    = long0_r;
endmodule
`default_nettype wire

/* dv/tb_logic_compare_call_exec.sv */
// Self-checking bench for the logic, compare and call execution block
`timescale 1ns/100ps
`default_nettype none
module tb_logic_compare_call_exec
  import logic_compare_call_pkg::*;
;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hubGrant;
  logic        hubReq;
  logic [7:0]  clockMode;
  int          numErrors;
  int          totalChecks;
  int          n;
  logic        expZ;
  logic        expC;
  logic [8:0]  expPc;
  logic [31:0] q;
  logic        e;
  logic        storeLong0;
  logic [31:0] long0Data;
  logic [31:0] long0;

  logic_compare_call_exec u_logic_compare_call_exec (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hubGrant(hubGrant), .hubReq(hubReq), .clockMode(clockMode)
  );
  hub_window_model u_hub_window_model (
    .clk(clk), .reset(reset), .storeLong0(storeLong0), .long0Data(long0Data),
    .hubGrant(hubGrant), .long0(long0)
  );

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("Checks %0d, mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Waits for pready with no assumed latency; an idle cycle separates transfers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    if (k >= 16) begin
      numErrors++;
      $display("ERROR at %0t: no pready", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic setReg(input logic [8:0] idx, input logic [31:0] d);
    apb(1'h1, OFS_REG_INDEX, {23'h0, idx});
    apb(1'h1, OFS_REG_DATA, d);
  endtask

  task automatic getReg(input logic [8:0] idx);
    apb(1'h1, OFS_REG_INDEX, {23'h0, idx});
    apb(1'h0, OFS_REG_DATA, 32'h0);
  endtask

  task automatic stateCheck();
    apb(1'h0, OFS_STATUS, 32'h0);
    check({30'h0, q[STAT_CARRY_BIT], q[STAT_ZERO_BIT]}, {30'h0, expC, expZ});
    apb(1'h0, OFS_PC, 32'h0);
    check(q, {23'h0, expPc});
  endtask

  task automatic issue(input logic [31:0] w);
    apb(1'h1, OFS_INSTR, w);
    check({31'h0, e}, 32'h0);
    apb(1'h0, OFS_STATUS, 32'h0);
    check({31'h0, q[STAT_BUSY_BIT]}, 32'h1);
    apb(1'h0, OFS_STATUS, 32'h0);
    check({31'h0, q[STAT_BUSY_BIT]}, 32'h0);
  endtask

  task automatic doOp(input logic [5:0] op, input logic z, input logic c, input logic r,
                      input logic i, input logic [3:0] cnd, input logic [31:0] a,
                      input logic [31:0] b);
    logic [31:0] sv;
    logic [31:0] res;
    logic        isLogic;
    logic        run;
    sv = i ? {23'h0, b[8:0]} : b;
    isLogic = (op == OP_AND) || (op == OP_BIT_CLEAR);
    res = (op == OP_AND) ? (a & sv) : (op == OP_BIT_CLEAR) ? (a & ~sv) : (a - sv);
    run = cnd[{expC, expZ}];
    setReg(9'h005, a);
    setReg(9'h006, b);
    issue({op, z, c, r, i, cnd, 9'h005, i ? b[8:0] : 9'h006});
    expPc = expPc + 9'h001;
    if (run && z) expZ = isLogic ? (res == 32'h0) : (a == sv);
    if (run && c) begin
      expC = isLogic ? ^res : (op == OP_UCOMPARE) ? (a < sv) : ($signed(a) < $signed(sv));
    end
    getReg(9'h005);
    check(q, (run && r) ? res : a);
    stateCheck();
  endtask

  initial begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    storeLong0 = 1'h0;
    long0Data = 32'h0;
    numErrors = 0;
    totalChecks = 0;
    expZ = 1'h0;
    expC = 1'h0;
    expPc = PC_RST;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    check({24'h0, clockMode}, {24'h0, CLOCK_MODE_RST});
    stateCheck();
    $display("test reset done");
    doOp(OP_AND, 1'h1, 1'h1, 1'h1, 1'h0, COND_ALWAYS, 32'hf0f0_1234, 32'h0ff0_00ff);
    doOp(OP_BIT_CLEAR, 1'h1, 1'h1, 1'h1, 1'h1, COND_ALWAYS, 32'h1ff, 32'h1ff);
    doOp(OP_AND, 1'h0, 1'h1, 1'h0, 1'h1, COND_ALWAYS, 32'h7, 32'h103);
    doOp(OP_BIT_CLEAR, 1'h1, 1'h0, 1'h1, 1'h0, COND_ALWAYS, 32'hffff0000, 32'h0f0f0f0f);
    doOp(OP_AND, 1'h1, 1'h1, 1'h1, 1'h0, 4'h0, 32'h5, 32'h3);
    $display("test conjunction done");
    doOp(OP_UCOMPARE, 1'h1, 1'h1, 1'h0, 1'h0, COND_ALWAYS, 32'h5, 32'hffff_fff0);
    doOp(OP_UCOMPARE, 1'h1, 1'h1, 1'h0, 1'h1, COND_ALWAYS, 32'h123, 32'h123);
    doOp(OP_SCOMPARE, 1'h1, 1'h1, 1'h0, 1'h0, COND_ALWAYS, 32'hffff_fff0, 32'h5);
    doOp(OP_SCOMPARE, 1'h1, 1'h1, 1'h0, 1'h0, COND_ALWAYS, 32'h5, 32'h5);
    doOp(OP_SCOMPARE, 1'h0, 1'h1, 1'h1, 1'h0, COND_ALWAYS, 32'h5, 32'hffff_fff0);
    $display("test compare done");
    apb(1'h1, OFS_PC, 32'h40);
    expPc = 9'h123;
    setReg(9'h014, 32'ha5a5_a5a5);
    issue({OP_JUMP_LINK, 4'h3, COND_ALWAYS, 9'h014, 9'h123});
    getReg(9'h014);
    check(q, (32'ha5a5_a5a5 & 32'hffff_fe00) | 32'h41);
    stateCheck();
    apb(1'h1, OFS_PC, 32'h80);
    expPc = 9'h0c8;
    issue({OP_JUMP_LINK, 4'h1, COND_ALWAYS, 9'h014, 9'h0c8});
    getReg(9'h014);
    check(q, (32'ha5a5_a5a5 & 32'hffff_fe00) | 32'h41);
    stateCheck();
    // Register source: register 6 still holds the last compare operand
    issue({OP_JUMP_LINK, 4'h2, COND_ALWAYS, 9'h014, 9'h006});
    expPc = 9'h1f0;
    getReg(9'h014);
    check(q, (32'ha5a5_a5a5 & 32'hffff_fe00) | 32'hc9);
    stateCheck();
    $display("test call done");
    apb(1'h0, 8'h14, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'h1, OFS_INSTR, {6'h20, 4'h3, COND_ALWAYS, 18'h0});
    check({31'h0, e}, 32'h1);
    apb(1'h1, OFS_INSTR, {OP_HUB, 4'h1, COND_ALWAYS, 9'h007, 9'h001});
    check({31'h0, e}, 32'h1);
    apb(1'h1, OFS_INSTR, {OP_AND, 4'h0, COND_ALWAYS, 9'h005, 9'h005});
    check({31'h0, e}, 32'h0);
    apb(1'h1, OFS_INSTR, {OP_AND, 4'h0, COND_ALWAYS, 9'h005, 9'h005});
    check({31'h0, e}, 32'h1);
    expPc = expPc + 9'h001;
    stateCheck();
    $display("test refusal done");
    setReg(9'h007, 32'h1234_566b);
    apb(1'h1, OFS_INSTR, {OP_HUB, 4'h1, COND_ALWAYS, 9'h007, 6'h00, HUB_CLOCK_MODE_WRITE});
    expPc = expPc + 9'h001;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hubReq === 1'h1 && n < 40);
    check({31'h0, n >= HUB_MIN_CYCLES && n <= HUB_MAX_CYCLES}, 32'h1);
    check({24'h0, clockMode}, 32'h6b);
    apb(1'h0, OFS_STATUS, 32'h0);
    check({24'h0, q[STAT_MODE_LSB +: 8]}, 32'h6b);
    stateCheck();
    getReg(9'h007);
    check(q, 32'h1234_566b);
    apb(1'h0, OFS_INSTR, 32'h0);
    check(q, {OP_HUB, 4'h1, COND_ALWAYS, 9'h007, 6'h00, HUB_CLOCK_MODE_WRITE});
    // The program then publishes the new frequency at main memory long 0
    storeLong0 <= 1'h1;
    long0Data <= 32'h0131_2d00;
    @(posedge clk);
    storeLong0 <= 1'h0;
    @(posedge clk);
    check(long0, 32'h0131_2d00);
    $display("test clock mode done");
    giveVerdict();
  end

  // Whole run needs several hundred cycles; this bound only catches a hang
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    $display("ERROR at %0t: run timed out", $time);
    giveVerdict();
  end
endmodule
`default_nettype wire
